// >>> include/bea_pkg.sv
// Package for the byte EEPROM access controller: offsets, fields, timing and bus carriers.
package bea_pkg;

	// ----------------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// ----------------------------------------------------------------------
	localparam logic [7:0] IDX_CONTROL = 8'h1F;
	localparam logic [7:0] IDX_DATA = 8'h20;
	localparam logic [7:0] IDX_ADDR_LO = 8'h21;
	localparam logic [7:0] IDX_ADDR_HI = 8'h22;

	// ----------------------------------------------------------------------
	// Control register fields.
	// ----------------------------------------------------------------------
	localparam int READ_STROBE_BIT = 0;
	localparam int PROGRAM_STROBE_BIT = 1;
	localparam int MASTER_ARM_BIT = 2;
	localparam int READY_IRQ_ENABLE_BIT = 3;
	localparam int PROGRAM_MODE_LO_BIT = 4;
	localparam int PROGRAM_MODE_HI_BIT = 5;

	// ----------------------------------------------------------------------
	// Sizes, reset values and encodings.
	// ----------------------------------------------------------------------
	localparam int NVM_BYTES = 64;
	localparam logic [5:0] NVM_LAST_ADDR = 6'h3F;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [5:0] ADDR_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_ATOMIC = 2'h0,
		MODE_ERASE = 2'h1,
		MODE_WRITE = 2'h2,
		MODE_RESERVED = 2'h3
	} bea_mode_e;

	// ----------------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned OSC_HZ = 8_000_000;
	localparam int unsigned PRESCALE_DIV = CLK_HZ / OSC_HZ;
	localparam int unsigned ATOMIC_TIME_US = 3400;
	localparam int unsigned SPLIT_TIME_US = 1800;
	localparam int unsigned ATOMIC_TICKS = ATOMIC_TIME_US * (OSC_HZ / 1_000_000);
	localparam int unsigned SPLIT_TICKS = SPLIT_TIME_US * (OSC_HZ / 1_000_000);
	localparam logic [2:0] ARM_CYCLES = 3'd4;
	localparam logic [2:0] READ_STALL_CYCLES = 3'd4;
	localparam logic [2:0] PROG_STALL_CYCLES = 3'd2;

	// ----------------------------------------------------------------------
	// AXI4-Lite carriers.
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [9:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [9:0] araddr;
		logic arvalid;
		logic rready;
	} bea_axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} bea_axil_rsp_s;

endpackage : bea_pkg

// >>> rtl/bea_nvm_ctrl.sv
// Byte EEPROM access controller with an AXI4-Lite register slave.
`timescale 1ns/1ps
// Functional notes
// - Hold 64 bytes at linear addresses 0x00 to 0x3F, byte access.
// - Time erase and write from an 8 MHz tick, not the bus clock; here the tick is the bus clock divided by 5.
// - Atomic mode erases the byte then writes it in one operation.
// - Erase-only and write-only run as separate shorter operations.
// - Two-bit mode field selects atomic, erase-only or write-only.
// - Completion seen by program strobe clearing or the ready interrupt.
// - Ready interrupt only while ready interrupt enable is set.
// - Address then read strobe; CPU stalled four cycles.
// - Read byte appears in the data register for software.
// - Program strobe starts only within four cycles after the arm bit.
// - Starting an erase or write stalls the CPU two cycles.
// - Program strobe stays set for the whole operation, then clears.
// - No read, erase or write may start while programming.
// - A running program operation completes even through reset.
// - Modes: 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - Arm bit clears by itself four cycles after being set.
// - Mode field writes ignored while program strobe is set.
// - Ready interrupt raised whenever idle and enabled.

module bea_nvm_ctrl #(
	parameter int unsigned ATOMIC_TICKS = bea_pkg::ATOMIC_TICKS,
	parameter int unsigned SPLIT_TICKS = bea_pkg::SPLIT_TICKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire bea_pkg::bea_axil_req_s axil_req,
	output bea_pkg::bea_axil_rsp_s axil_rsp,
	output logic cpu_halt,
	output logic nvm_ready_irq
);

	typedef enum logic {
		PG_IDLE,
		PG_RUN
	} bea_prog_e;

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	function automatic logic [7:0] reg_index(input logic [9:0] byte_addr);
		reg_index = byte_addr[9:2];
	endfunction : reg_index

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx == bea_pkg::IDX_CONTROL) || (idx == bea_pkg::IDX_DATA) ||
			(idx == bea_pkg::IDX_ADDR_LO) || (idx == bea_pkg::IDX_ADDR_HI);
	endfunction : is_mapped

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	logic [7:0] mem_reg [bea_pkg::NVM_BYTES];
	logic [7:0] mem_next [bea_pkg::NVM_BYTES];
	logic [5:0] addr_reg, addr_next;
	logic [7:0] data_reg, data_next;
	logic [1:0] mode_reg, mode_next;
	logic irq_en_reg, irq_en_next;
	logic arm_reg, arm_next;
	logic [2:0] arm_cnt_reg, arm_cnt_next;
	logic [2:0] stall_cnt_reg, stall_cnt_next;
	logic cpu_halt_reg, cpu_halt_next;
	logic irq_reg, irq_next;
	bea_prog_e prog_reg, prog_next;
	logic [1:0] prog_mode_reg, prog_mode_next;
	logic [5:0] prog_addr_reg, prog_addr_next;
	logic [7:0] prog_data_reg, prog_data_next;
	logic [15:0] tick_cnt_reg, tick_cnt_next;
	logic [2:0] presc_reg, presc_next;
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [9:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	bea_pkg::bea_axil_rsp_s rsp_reg, rsp_next;

	logic busy;
	logic osc_tick;
	logic do_write;
	logic [7:0] w_idx;
	logic [7:0] r_idx;
	logic [7:0] wbyte;
	logic [15:0] op_ticks;

	assign axil_rsp = rsp_reg;
	assign cpu_halt = cpu_halt_reg;
	assign nvm_ready_irq = irq_reg;

	// ----------------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------------
	always_comb begin
		mem_next = mem_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		mode_next = mode_reg;
		irq_en_next = irq_en_reg;
		arm_next = arm_reg;
		arm_cnt_next = arm_cnt_reg;
		stall_cnt_next = (stall_cnt_reg != 3'd0) ? stall_cnt_reg - 3'd1 : 3'd0;
		prog_next = prog_reg;
		prog_mode_next = prog_mode_reg;
		prog_addr_next = prog_addr_reg;
		prog_data_next = prog_data_reg;
		tick_cnt_next = tick_cnt_reg;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		rsp_next = rsp_reg;
		busy = (prog_reg == PG_RUN);
		w_idx = reg_index(awaddr_reg);
		r_idx = reg_index(axil_req.araddr);
		wbyte = wdata_reg[7:0];
		op_ticks = (prog_mode_reg == bea_pkg::MODE_ATOMIC) ? 16'(ATOMIC_TICKS) :
			16'(SPLIT_TICKS);

		// The 8 MHz programming time base is a fixed division of the bus clock.
		osc_tick = (presc_reg == 3'(bea_pkg::PRESCALE_DIV - 1));
		presc_next = osc_tick ? 3'd0 : presc_reg + 3'd1;

		// Arm window: high for four cycles, then dropped by hardware; a program start drops it sooner.
		if (arm_reg) begin
			arm_cnt_next = arm_cnt_reg - 3'd1;
			if (arm_cnt_reg == 3'd1) begin
				arm_next = 1'b0;
			end
		end

		// Programming operation; the result lands in storage when the time is up.
		if (busy && osc_tick) begin
			tick_cnt_next = tick_cnt_reg + 16'd1;
			if (tick_cnt_reg == op_ticks - 16'd1) begin
				unique case (bea_pkg::bea_mode_e'(prog_mode_reg))
					bea_pkg::MODE_ATOMIC: begin
						// Erase then write leaves exactly the new byte.
						mem_next[prog_addr_reg] = prog_data_reg;
					end
					bea_pkg::MODE_ERASE: begin
						mem_next[prog_addr_reg] = bea_pkg::ERASED_BYTE;
					end
					bea_pkg::MODE_WRITE: begin
						// Writing can only clear bits, so an unerased byte corrupts.
						mem_next[prog_addr_reg] = mem_reg[prog_addr_reg] & prog_data_reg;
					end
					default: begin
						mem_next[prog_addr_reg] = mem_reg[prog_addr_reg];
					end
				endcase
				prog_next = PG_IDLE;
			end
		end

		// AXI write address and data are taken in either order.
		if (axil_req.awvalid && rsp_reg.awready) begin
			aw_have_next = 1'b1;
			awaddr_next = axil_req.awaddr;
		end
		if (axil_req.wvalid && rsp_reg.wready) begin
			w_have_next = 1'b1;
			wdata_next = axil_req.wdata;
			wstrb_next = axil_req.wstrb;
		end
		if (rsp_reg.bvalid && axil_req.bready) begin
			rsp_next.bvalid = 1'b0;
		end
		do_write = aw_have_reg && w_have_reg && !rsp_reg.bvalid;
		if (do_write) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			rsp_next.bvalid = 1'b1;
			rsp_next.bresp = is_mapped(w_idx) ? bea_pkg::RESP_OKAY : bea_pkg::RESP_SLVERR;
		end

		// Register write effects; only the low byte lane carries data.
		if (do_write && wstrb_reg[0]) begin
			if (w_idx == bea_pkg::IDX_ADDR_LO && !busy) begin
				addr_next = wbyte[5:0];
			end
			if (w_idx == bea_pkg::IDX_DATA) begin
				data_next = wbyte;
			end
			if (w_idx == bea_pkg::IDX_CONTROL) begin
				irq_en_next = wbyte[bea_pkg::READY_IRQ_ENABLE_BIT];
				if (!busy) begin
					mode_next = wbyte[bea_pkg::PROGRAM_MODE_HI_BIT:bea_pkg::PROGRAM_MODE_LO_BIT];
				end
				if (wbyte[bea_pkg::MASTER_ARM_BIT] && !arm_reg) begin
					arm_next = 1'b1;
					arm_cnt_next = bea_pkg::ARM_CYCLES;
				end
				// Start needs an already open arm window and an idle array.
				if (wbyte[bea_pkg::PROGRAM_STROBE_BIT] && arm_reg && !busy &&
					mode_reg != bea_pkg::MODE_RESERVED) begin
					prog_next = PG_RUN;
					prog_mode_next = mode_reg;
					prog_addr_next = addr_reg;
					prog_data_next = data_reg;
					tick_cnt_next = 16'd0;
					arm_next = 1'b0;
					stall_cnt_next = bea_pkg::PROG_STALL_CYCLES;
				end
				if (wbyte[bea_pkg::READ_STROBE_BIT] && !busy) begin
					data_next = mem_reg[addr_reg];
					stall_cnt_next = bea_pkg::READ_STALL_CYCLES;
				end
			end
		end

		// AXI read: one outstanding, answered one cycle after the address.
		if (rsp_reg.rvalid && axil_req.rready) begin
			rsp_next.rvalid = 1'b0;
		end
		if (axil_req.arvalid && rsp_reg.arready) begin
			rsp_next.rvalid = 1'b1;
			rsp_next.rresp = is_mapped(r_idx) ? bea_pkg::RESP_OKAY : bea_pkg::RESP_SLVERR;
			rsp_next.rdata = 32'h0000_0000;
			if (r_idx == bea_pkg::IDX_CONTROL) begin
				rsp_next.rdata[bea_pkg::PROGRAM_MODE_HI_BIT:bea_pkg::PROGRAM_MODE_LO_BIT] =
					mode_reg;
				rsp_next.rdata[bea_pkg::READY_IRQ_ENABLE_BIT] = irq_en_reg;
				rsp_next.rdata[bea_pkg::MASTER_ARM_BIT] = arm_reg;
				rsp_next.rdata[bea_pkg::PROGRAM_STROBE_BIT] = busy;
			end else if (r_idx == bea_pkg::IDX_DATA) begin
				rsp_next.rdata[7:0] = data_reg;
			end else if (r_idx == bea_pkg::IDX_ADDR_LO) begin
				rsp_next.rdata[5:0] = addr_reg;
			end
		end

		// Synchronous reset leaves a running program operation untouched.
		if (!aresetn) begin
			addr_next = bea_pkg::ADDR_RESET;
			data_next = bea_pkg::DATA_RESET;
			irq_en_next = 1'b0;
			arm_next = 1'b0;
			arm_cnt_next = 3'd0;
			stall_cnt_next = 3'd0;
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			awaddr_next = 10'h000;
			wdata_next = 32'h0000_0000;
			wstrb_next = 4'h0;
			rsp_next = '0;
			// An unknown busy at power-up takes the else branch, so the first reset clears it.
			if (busy) begin
				mode_next = mode_reg;
			end else begin
				mode_next = bea_pkg::MODE_RESET;
				prog_next = PG_IDLE;
				prog_mode_next = bea_pkg::MODE_RESET;
				prog_addr_next = bea_pkg::ADDR_RESET;
				prog_data_next = bea_pkg::DATA_RESET;
				tick_cnt_next = 16'd0;
				presc_next = 3'd0;
			end
		end

		// Ready lines are registered, so they follow the next holding state.
		rsp_next.awready = aresetn && !aw_have_next && !rsp_next.bvalid;
		rsp_next.wready = aresetn && !w_have_next && !rsp_next.bvalid;
		rsp_next.arready = aresetn && !rsp_next.rvalid;
		cpu_halt_next = (stall_cnt_next != 3'd0);
		irq_next = irq_en_next && (prog_next == PG_IDLE);
	end

	// ----------------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		mem_reg <= mem_next;
		addr_reg <= addr_next;
		data_reg <= data_next;
		mode_reg <= mode_next;
		irq_en_reg <= irq_en_next;
		arm_reg <= arm_next;
		arm_cnt_reg <= arm_cnt_next;
		stall_cnt_reg <= stall_cnt_next;
		cpu_halt_reg <= cpu_halt_next;
		irq_reg <= irq_next;
		prog_reg <= prog_next;
		prog_mode_reg <= prog_mode_next;
		prog_addr_reg <= prog_addr_next;
		prog_data_reg <= prog_data_next;
		tick_cnt_reg <= tick_cnt_next;
		presc_reg <= presc_next;
		aw_have_reg <= aw_have_next;
		w_have_reg <= w_have_next;
		awaddr_reg <= awaddr_next;
		wdata_reg <= wdata_next;
		wstrb_reg <= wstrb_next;
		rsp_reg <= rsp_next;
	end

endmodule : bea_nvm_ctrl

// >>> verif/bea_nvm_ctrl_asserts.sv
// Port checker for the byte EEPROM access controller.
`timescale 1ns/1ps
module bea_nvm_ctrl_asserts #(
	parameter int unsigned ATOMIC_TICKS = 20,
	parameter int unsigned SPLIT_TICKS = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire bea_pkg::bea_axil_req_s axil_req,
	input wire bea_pkg::bea_axil_rsp_s axil_rsp,
	input wire logic cpu_halt,
	input wire logic nvm_ready_irq
);
	// ----------
	// Read address tracking
	// ----------
	logic [7:0] ar_idx_reg;
	logic [7:0] ar_idx_next;
	logic ar_map;
	always_comb begin
		ar_idx_next = ar_idx_reg;
		if (axil_req.arvalid && axil_rsp.arready) begin
			ar_idx_next = axil_req.araddr[9:2];
		end
	end
	always_ff @(posedge aclk) begin
		ar_idx_reg <= ar_idx_next;
	end
	assign ar_map = ar_idx_reg inside {8'h1f, 8'h20, 8'h21, 8'h22};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_halt_length: assert property ($rose(cpu_halt) |-> cpu_halt[*2] ##1
		(!cpu_halt or (cpu_halt[*2] ##1 !cpu_halt))) else $error("halt length wrong");
	a_bresp_holds: assert property (axil_rsp.bvalid && !axil_req.bready |=>
		axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("bvalid dropped early");
	a_rdata_holds: assert property (axil_rsp.rvalid && !axil_req.rready |=>
		axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("rdata not held");
	a_ar_blocked: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
		else $error("arready while rvalid");
	a_read_latency: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
		else $error("rvalid late");
	a_write_latency: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid
		&& axil_rsp.wready |-> ##2 axil_rsp.bvalid) else $error("bvalid late");
	a_upper_zero: assert property (axil_rsp.rvalid |-> axil_rsp.rdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_unmapped_err: assert property (axil_rsp.rvalid && !ar_map |->
		axil_rsp.rresp == bea_pkg::RESP_SLVERR && axil_rsp.rdata == 32'h0000_0000)
		else $error("unmapped read answered");
	a_mapped_okay: assert property (axil_rsp.rvalid && ar_map |->
		axil_rsp.rresp == bea_pkg::RESP_OKAY) else $error("mapped read refused");
endmodule : bea_nvm_ctrl_asserts
bind bea_nvm_ctrl bea_nvm_ctrl_asserts #(.ATOMIC_TICKS(ATOMIC_TICKS), .SPLIT_TICKS(SPLIT_TICKS))
	u_chk (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
	.cpu_halt(cpu_halt), .nvm_ready_irq(nvm_ready_irq));

// >>> verif/bea_nvm_ctrl_tb.sv
// Self-checking testbench for the byte EEPROM access controller.
`timescale 1ns/1ps
module bea_nvm_ctrl_tb;
	localparam int AT = 20;
	localparam int ST = 10;
	localparam logic [7:0] CTL = bea_pkg::IDX_CONTROL;
	localparam logic [7:0] DAT = bea_pkg::IDX_DATA;
	localparam logic [7:0] ADL = bea_pkg::IDX_ADDR_LO;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	bea_pkg::bea_axil_req_s req = '0;
	bea_pkg::bea_axil_rsp_s rsp;
	logic halt;
	logic irq;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int halt_n = 0;
	int h;
	int n;
	logic [31:0] rdv;
	logic [1:0] rsv;
	logic [1:0] md [5] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
	logic [5:0] ad [5] = '{6'h3f, 6'h3f, 6'h3f, 6'h00, 6'h00};
	logic [7:0] dv [5] = '{8'h00, 8'ha5, 8'h0f, 8'h3c, 8'h00};
	logic [7:0] ex [5] = '{8'hff, 8'ha5, 8'h05, 8'h3c, 8'h3c};
	bea_nvm_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) uut (.aclk(aclk), .aresetn(aresetn),
		.axil_req(req), .axil_rsp(rsp), .cpu_halt(halt), .nvm_ready_irq(irq));
	always #12.5 aclk = ~aclk;
	// The ceiling is several times the expected run so slow polls never trip it.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (halt === 1'b1) halt_n <= halt_n + 1;
		if (cyc == 6000) begin
			fail_count++;
			report_and_stop();
		end
	end
	// ----------
	// Bus tasks
	// ----------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input bit lazy = 1'b0);
		bit a = 0;
		bit w = 0;
		bit b = 0;
		req.awaddr <= {i, 2'b00};
		req.awvalid <= 1'b1;
		req.wdata <= {24'h00_0000, d};
		req.wstrb <= 4'hf;
		req.wvalid <= 1'b1;
		// A lazy write leaves bvalid waiting one cycle, so the response hold is exercised.
		req.bready <= !lazy;
		while (!b) begin
			@(posedge aclk);
			if (!a && rsp.awready) begin
				a = 1;
				req.awvalid <= 1'b0;
			end
			if (!w && rsp.wready) begin
				w = 1;
				req.wvalid <= 1'b0;
			end
			if (rsp.bvalid && req.bready) begin
				b = 1;
				rsv = rsp.bresp;
			end else if (rsp.bvalid) begin
				req.bready <= 1'b1;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] i);
		bit a = 0;
		bit b = 0;
		req.araddr <= {i, 2'b00};
		req.arvalid <= 1'b1;
		// Reads always stall rvalid one cycle, so the read data hold is exercised.
		req.rready <= 1'b0;
		while (!b) begin
			@(posedge aclk);
			if (!a && rsp.arready) begin
				a = 1;
				req.arvalid <= 1'b0;
			end
			if (rsp.rvalid && req.rready) begin
				b = 1;
				rdv = rsp.rdata;
				rsv = rsp.rresp;
			end else if (rsp.rvalid) begin
				req.rready <= 1'b1;
			end
		end
	endtask : rd
	task automatic prog(input logic [1:0] m, input logic [5:0] a, input logic [7:0] d);
		wr(CTL, {2'b00, m, 4'h8});
		wr(ADL, {2'b00, a});
		wr(DAT, d, 1'b1);
		wr(CTL, {2'b00, m, 4'hc});
		wr(CTL, {2'b00, m, 4'ha});
	endtask : prog
	task automatic wait_idle(output int cnt);
		int t;
		t = cyc;
		do rd(CTL); while (rdv[1] === 1'b1 && cyc - t < 3000);
		cnt = cyc - t;
	endtask : wait_idle
	task automatic nvm_rd(input logic [5:0] a, input logic [7:0] e);
		int h0;
		wr(ADL, {2'b00, a});
		h0 = halt_n;
		wr(CTL, 8'h09);
		rd(DAT);
		repeat (3) @(posedge aclk);
		chk("halt_read", 4, halt_n - h0);
		chk("nvm_data", {24'h00_0000, e}, rdv);
	endtask : nvm_rd
	task report_and_stop();
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	// ----------
	// Main sequence
	// ----------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int k = 0; k < 4; k++) begin
			rd(8'(CTL + k));
			chk("reset_val", 0, rdv);
		end
		rd(8'h00);
		chk("bad_rresp", 32'(bea_pkg::RESP_SLVERR), 32'(rsv));
		wr(8'h40, 8'hff);
		chk("bad_bresp", 32'(bea_pkg::RESP_SLVERR), 32'(rsv));
		chk("irq_off", 0, 32'(irq));
		wr(CTL, 8'h08);
		repeat (2) @(posedge aclk);
		chk("irq_on", 1, 32'(irq));
		wr(CTL, 8'h0a);
		rd(CTL);
		chk("no_arm", 0, 32'(rdv[1]));
		wr(CTL, 8'h0c);
		repeat (6) @(posedge aclk);
		wr(CTL, 8'h0a);
		rd(CTL);
		chk("arm_expired", 32'h0000_0008, rdv);
		for (int k = 0; k < 5; k++) begin
			h = halt_n;
			prog(md[k], ad[k], dv[k]);
			rd(CTL);
			chk("busy", 32'(md[k] != 2'h3), 32'(rdv[1]));
			chk("mode", 32'(md[k]), 32'(rdv[5:4]));
			chk("halt_prog", (md[k] != 2'h3) ? 2 : 0, halt_n - h);
			chk("irq_busy", 32'(md[k] == 2'h3), 32'(irq));
			wait_idle(n);
			h = ((md[k] == 2'h0) ? AT : ST) * int'(bea_pkg::PRESCALE_DIV);
			if (md[k] != 2'h3) chk("prog_time", 1, 32'(n >= h - 12 && n <= h + 6));
			nvm_rd(ad[k], ex[k]);
		end
		prog(2'h1, 6'h00, 8'h77);
		wr(CTL, 8'h29);
		wr(ADL, 8'h3f);
		wr(CTL, 8'h1c);
		wr(CTL, 8'h1a);
		rd(CTL);
		chk("mode_lock", 1, 32'(rdv[5:4]));
		rd(DAT);
		chk("data_kept", 32'h0000_0077, rdv);
		rd(ADL);
		chk("addr_kept", 0, rdv);
		wait_idle(n);
		nvm_rd(6'h00, 8'hff);
		nvm_rd(6'h3f, 8'h05);
		prog(2'h2, 6'h00, 8'h5a);
		repeat (4) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(CTL);
		chk("busy_reset", 32'h0000_0022, rdv);
		wait_idle(n);
		nvm_rd(6'h00, 8'h5a);
		report_and_stop();
	end
endmodule : bea_nvm_ctrl_tb
